// [src/ppcs_pkg.sv]
// Package of the PHY port control and status bank: register map,
// field positions, reset values, timing counts and carrier types.
// Assumes a 32-bit APB with one register per aligned word.

package ppcs_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_P1_CTRL = 8'h1D;
  localparam logic [7:0] IDX_P1_STAT = 8'h1E;
  localparam logic [7:0] IDX_P2_CTRL = 8'h2D;
  localparam logic [7:0] IDX_P2_STAT = 8'h2E;
  localparam logic [7:0] IDX_P3_RSVD = 8'h3E;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
  localparam logic [7:0] IDX_IRQ_EN = 8'h41;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h42;

  // ------------------------------------------------------------
  // Control field positions, writable masks and reset values
  // ------------------------------------------------------------
  localparam int CTL_FEF_OFF = 4;
  localparam int CTL_PWR_DOWN = 3;
  localparam int CTL_XOVER_DIS = 2;
  localparam int CTL_FORCE_MDI = 1;
  localparam int CTL_LOOP = 0;
  localparam logic [7:0] P1_CTL_MASK = 8'h1F;
  localparam logic [7:0] P2_CTL_MASK = 8'h0F;
  localparam logic [7:0] CTL_RST = 8'h00;

  // ------------------------------------------------------------
  // Status field positions and reset value
  // ------------------------------------------------------------
  localparam int STA_MDIX = 7;
  localparam int STA_AN_DONE = 6;
  localparam int STA_LINK = 5;
  localparam int STA_PAUSE = 4;
  localparam int STA_100FD = 3;
  localparam int STA_100HD = 2;
  localparam int STA_10FD = 1;
  localparam int STA_10HD = 0;
  localparam logic [7:0] STAT_RST = 8'h00;

  // ------------------------------------------------------------
  // Interrupt bits, reset values and timing
  // ------------------------------------------------------------
  localparam int IRQ_N = 4;
  localparam int IRQ_P1_LINK = 0;
  localparam int IRQ_P2_LINK = 1;
  localparam int IRQ_P1_AN = 2;
  localparam int IRQ_P2_AN = 3;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // ------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic fef_off;
    logic power_down;
    logic xover_auto;
    logic tx_on_rx_pair;
    logic loop_en;
  } ppcs_phy_ctl_t;

endpackage : ppcs_pkg

// [src/ppcs_sync3.sv]
// Three-stage input synchroniser with agreement filter per bit.
// Assumes inputs arrive from outside the pclk domain.

`timescale 1ns/1ps
`default_nettype none

module ppcs_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;
  logic [W-1:0] q_r;

  initial begin
    if (W < 1) $error("ppcs_sync3: W must be at least 1");
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_r <= '0;
      ff2_r <= '0;
      ff3_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      ff1_r <= d;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      q_r <= (~(ff2_r ^ ff3_r) & ff3_r) | ((ff2_r ^ ff3_r) & q_r);
    end
  end

  assign q = q_r;

endmodule : ppcs_sync3

`default_nettype wire

// [src/ppcs_irq.sv]
// Sticky event status with enable mask and write-one-to-clear.
// Assumes the caller gives one-cycle write strobes on pclk.

`timescale 1ns/1ps
`default_nettype none

module ppcs_irq #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Events and software access
  input wire logic [N-1:0] evt,
  input wire logic en_we,
  input wire logic clr_we,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);

  logic [N-1:0] stat_r;
  logic [N-1:0] en_r;

  initial begin
    if (N < 1 || N > 32) $error("ppcs_irq: N out of range");
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else if (ce) begin
      stat_r <= (stat_r & ~(clr_we ? wdata : '0)) | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= N'(ppcs_pkg::IRQ_EN_RST);
    end else if (ce && en_we) begin
      en_r <= wdata;
    end
  end

  assign status = stat_r;
  assign enable = en_r;
  assign irq = |(stat_r & en_r);

endmodule : ppcs_irq

`default_nettype wire

// [src/ppcs_top.sv]
// PHY port control and status bank for the two PHY ports.
// Assumes APB on pclk, PHY status pins asynchronous to pclk,
// and symbol streams already on pclk.

`timescale 1ns/1ps
`default_nettype none

module ppcs_top #(
  parameter int SYM_W = 5
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PHY status pins and straps
  input wire logic [7:0] p1_phy_status,
  input wire logic [7:0] p2_phy_status,
  input wire logic port2_crossover_dis_strap,
  input wire logic port2_crossover_strap,
  // PHY control
  output ppcs_pkg::ppcs_phy_ctl_t p1_ctl,
  output ppcs_pkg::ppcs_phy_ctl_t p2_ctl,
  // Symbol streams at the PMD/PMA boundary
  input wire logic [SYM_W-1:0] first_port_receive_pins,
  input wire logic [SYM_W-1:0] second_port_receive_pins,
  input wire logic [SYM_W-1:0] p1_mac_tx_sym,
  input wire logic [SYM_W-1:0] p2_mac_tx_sym,
  output logic [SYM_W-1:0] first_port_transmit_pins,
  output logic [SYM_W-1:0] second_port_transmit_pins,
  // Interrupt
  output logic irq
);

  initial begin
    if (SYM_W < 1 || SYM_W > 16) $error("ppcs_top: SYM_W out of range");
  end

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ppcs_pkg::ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction : hit

  function automatic ppcs_pkg::ppcs_phy_ctl_t make_ctl(input logic [7:0] c,
                                                       input logic [7:0] s);
    ppcs_pkg::ppcs_phy_ctl_t r;
    r.fef_off = c[ppcs_pkg::CTL_FEF_OFF];
    r.power_down = c[ppcs_pkg::CTL_PWR_DOWN];
    r.xover_auto = ~c[ppcs_pkg::CTL_XOVER_DIS];
    // Forced mode when auto is off, else follow the PHY's choice
    r.tx_on_rx_pair = c[ppcs_pkg::CTL_XOVER_DIS] ? c[ppcs_pkg::CTL_FORCE_MDI]
                                                 : ~s[ppcs_pkg::STA_MDIX];
    r.loop_en = c[ppcs_pkg::CTL_LOOP];
    make_ctl = r;
  endfunction : make_ctl

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [17:0] sync_q;
  logic [7:0] st1;
  logic [7:0] st2;
  logic strap_dis;
  logic strap_mdi;

  ppcs_sync3 #(
    .W(18)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({port2_crossover_dis_strap, port2_crossover_strap,
        p2_phy_status, p1_phy_status}),
    .q(sync_q)
  );

  // Live PHY state, no latching
  assign st1 = sync_q[7:0];
  assign st2 = sync_q[15:8];
  assign strap_mdi = sync_q[16];
  assign strap_dis = sync_q[17];

  // ------------------------------------------------------------
  // Strap capture after reset release
  // ------------------------------------------------------------
  logic [2:0] strap_cnt_r;
  logic strap_done_r;
  logic strap_load;

  // Straps need the synchroniser filled before they can be trusted
  assign strap_load = ce && !strap_done_r && (strap_cnt_r == ppcs_pkg::STRAP_SETTLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r <= 3'h0;
      strap_done_r <= 1'b0;
    end else if (ce && !strap_done_r) begin
      if (strap_load) begin
        strap_done_r <= 1'b1;
      end else begin
        strap_cnt_r <= strap_cnt_r + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic setup;
  logic wr_acc;
  logic [31:0] rd_nxt;
  logic err_nxt;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [ppcs_pkg::IRQ_N-1:0] irq_stat;
  logic [ppcs_pkg::IRQ_N-1:0] irq_en;
  logic [7:0] ctl1_r;
  logic [7:0] ctl2_r;

  assign setup = psel && !penable;
  assign wr_acc = ce && psel && penable && pwrite;
  // Zero wait states: read data is staged during the setup cycle
  assign pready = 1'b1;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (hit(paddr, ppcs_pkg::IDX_P1_CTRL)) begin
      rd_nxt = {24'h00_0000, ctl1_r};
    end else if (hit(paddr, ppcs_pkg::IDX_P2_CTRL)) begin
      rd_nxt = {24'h00_0000, ctl2_r};
    end else if (hit(paddr, ppcs_pkg::IDX_P1_STAT)) begin
      rd_nxt = {24'h00_0000, st1};
    end else if (hit(paddr, ppcs_pkg::IDX_P2_STAT)) begin
      rd_nxt = {24'h00_0000, st2};
    end else if (hit(paddr, ppcs_pkg::IDX_P3_RSVD)) begin
      rd_nxt = 32'h0000_0000;
    end else if (hit(paddr, ppcs_pkg::IDX_IRQ_STAT)) begin
      rd_nxt = {28'h000_0000, irq_stat};
    end else if (hit(paddr, ppcs_pkg::IDX_IRQ_EN)) begin
      rd_nxt = {28'h000_0000, irq_en};
    end else if (hit(paddr, ppcs_pkg::IDX_IRQ_CLR)) begin
      rd_nxt = 32'h0000_0000;
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce && setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= err_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Upper control bits belong elsewhere and read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r <= ppcs_pkg::CTL_RST;
    end else if (wr_acc && hit(paddr, ppcs_pkg::IDX_P1_CTRL)) begin
      ctl1_r <= pwdata[7:0] & ppcs_pkg::P1_CTL_MASK;
    end
  end

  // Port two has no fiber, so its far-end-fault bit stays zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2_r <= ppcs_pkg::CTL_RST;
    end else if (wr_acc && hit(paddr, ppcs_pkg::IDX_P2_CTRL)) begin
      ctl2_r <= pwdata[7:0] & ppcs_pkg::P2_CTL_MASK;
    end else if (strap_load) begin
      ctl2_r[ppcs_pkg::CTL_XOVER_DIS] <= strap_dis;
      ctl2_r[ppcs_pkg::CTL_FORCE_MDI] <= strap_mdi;
    end
  end

  // ------------------------------------------------------------
  // PHY control outputs
  // ------------------------------------------------------------
  ppcs_pkg::ppcs_phy_ctl_t p1_ctl_r;
  ppcs_pkg::ppcs_phy_ctl_t p2_ctl_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_ctl_r <= '0;
      p2_ctl_r <= '0;
    end else if (ce) begin
      p1_ctl_r <= make_ctl(ctl1_r, st1);
      p2_ctl_r <= make_ctl(ctl2_r, st2);
    end
  end

  assign p1_ctl = p1_ctl_r;
  assign p2_ctl = p2_ctl_r;

  // ------------------------------------------------------------
  // Loopback symbol paths
  // ------------------------------------------------------------
  logic [SYM_W-1:0] p1_tx_r;
  logic [SYM_W-1:0] p2_tx_r;

  // A powered-down port sends idle zeros
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_tx_r <= '0;
      p2_tx_r <= '0;
    end else if (ce) begin
      if (ctl1_r[ppcs_pkg::CTL_PWR_DOWN]) begin
        p1_tx_r <= '0;
      end else if (ctl2_r[ppcs_pkg::CTL_LOOP]) begin
        p1_tx_r <= first_port_receive_pins;
      end else begin
        p1_tx_r <= p1_mac_tx_sym;
      end
      if (ctl2_r[ppcs_pkg::CTL_PWR_DOWN]) begin
        p2_tx_r <= '0;
      end else if (ctl1_r[ppcs_pkg::CTL_LOOP]) begin
        p2_tx_r <= second_port_receive_pins;
      end else begin
        p2_tx_r <= p2_mac_tx_sym;
      end
    end
  end

  assign first_port_transmit_pins = p1_tx_r;
  assign second_port_transmit_pins = p2_tx_r;

  // ------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------
  logic [7:0] st1_prev_r;
  logic [7:0] st2_prev_r;
  logic [ppcs_pkg::IRQ_N-1:0] evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st1_prev_r <= ppcs_pkg::STAT_RST;
      st2_prev_r <= ppcs_pkg::STAT_RST;
    end else if (ce) begin
      st1_prev_r <= st1;
      st2_prev_r <= st2;
    end
  end

  always_comb begin
    evt = '0;
    evt[ppcs_pkg::IRQ_P1_LINK] = st1[ppcs_pkg::STA_LINK] ^ st1_prev_r[ppcs_pkg::STA_LINK];
    evt[ppcs_pkg::IRQ_P2_LINK] = st2[ppcs_pkg::STA_LINK] ^ st2_prev_r[ppcs_pkg::STA_LINK];
    evt[ppcs_pkg::IRQ_P1_AN] = st1[ppcs_pkg::STA_AN_DONE] & ~st1_prev_r[ppcs_pkg::STA_AN_DONE];
    evt[ppcs_pkg::IRQ_P2_AN] = st2[ppcs_pkg::STA_AN_DONE] & ~st2_prev_r[ppcs_pkg::STA_AN_DONE];
  end

  ppcs_irq #(
    .N(ppcs_pkg::IRQ_N)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .evt(evt),
    .en_we(wr_acc && hit(paddr, ppcs_pkg::IDX_IRQ_EN)),
    .clr_we(wr_acc && hit(paddr, ppcs_pkg::IDX_IRQ_CLR)),
    .wdata(pwdata[ppcs_pkg::IRQ_N-1:0]),
    .status(irq_stat),
    .enable(irq_en),
    .irq(irq)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fef_port2_a: assert property (!ctl2_r[ppcs_pkg::CTL_FEF_OFF] && !p2_ctl.fef_off)
    else $error("port two far-end-fault bit set");

  pwr_follow_a: assert property (ce && ctl1_r[ppcs_pkg::CTL_PWR_DOWN] |=>
    p1_ctl.power_down && first_port_transmit_pins == '0)
    else $error("power-down not applied");

  auto_xover_a: assert property (ce && !ctl1_r[ppcs_pkg::CTL_XOVER_DIS] |=>
    p1_ctl.xover_auto && p1_ctl.tx_on_rx_pair == !$past(st1[ppcs_pkg::STA_MDIX]))
    else $error("auto crossover not followed");

  strap_load_a: assert property ($rose(strap_done_r) |->
    ctl2_r[2:1] == $past({strap_dis, strap_mdi}) || $past(wr_acc))
    else $error("strap not captured");

  force_mdi_a: assert property (ce && ctl2_r[ppcs_pkg::CTL_XOVER_DIS] |=>
    p2_ctl.tx_on_rx_pair == $past(ctl2_r[ppcs_pkg::CTL_FORCE_MDI]))
    else $error("forced crossover wrong");

  loop_p1_a: assert property (ce && ctl1_r[0] && !ctl2_r[3] |=>
    second_port_transmit_pins == $past(second_port_receive_pins))
    else $error("port one loopback path wrong");

  loop_p2_a: assert property (ce && ctl2_r[0] && !ctl1_r[3] |=>
    first_port_transmit_pins == $past(first_port_receive_pins))
    else $error("port two loopback path wrong");

  stat_read_a: assert property (ce && setup && !pwrite &&
    hit(paddr, ppcs_pkg::IDX_P2_STAT) |=> prdata == {24'h00_0000, $past(st2)} && !pslverr)
    else $error("status read mismatch");

  rsvd_read_a: assert property (ce && setup && hit(paddr, ppcs_pkg::IDX_P3_RSVD) |=>
    prdata == 32'h0000_0000 && !pslverr)
    else $error("reserved offset not zero");

  ctl_write_a: assert property (wr_acc && hit(paddr, ppcs_pkg::IDX_P1_CTRL) |=>
    ctl1_r == ($past(pwdata[7:0]) & ppcs_pkg::P1_CTL_MASK))
    else $error("control write lost");

endmodule : ppcs_top

`default_nettype wire

// [bench/ppcs_link_partner.sv]
// Far-end model: drives the PHY state pins and the receive symbols.
// Assumes pclk from the bench, which also sets the wanted partner state.

`timescale 1ns/1ps
`default_nettype none

module ppcs_link_partner #(
  parameter int SYM_W = 5
) (
  // Clock and pacing
  input wire logic pclk,
  input wire logic slow,
  // Wanted partner state
  input wire logic [7:0] st1_want,
  input wire logic [7:0] st2_want,
  // Pins toward the block
  output logic [7:0] p1_phy_status,
  output logic [7:0] p2_phy_status,
  output logic [SYM_W-1:0] first_port_receive_pins,
  output logic [SYM_W-1:0] second_port_receive_pins
);
  logic [15:0] lag_r [3];
  logic [15:0] sym_r = 16'h0000;

  // A slow partner settles its pins three cycles late
  always @(posedge pclk) begin
    lag_r[0] <= {st1_want, st2_want};
    lag_r[1] <= lag_r[0];
    lag_r[2] <= lag_r[1];
    sym_r <= sym_r * 16'h0005 + 16'h3B71;
  end

  assign {p1_phy_status, p2_phy_status} = slow ? lag_r[2] : {st1_want, st2_want};
  // First-port symbols change every cycle, so a stale loop path cannot match there; second-port symbols can repeat
  assign first_port_receive_pins = sym_r[SYM_W-1:0];
  assign second_port_receive_pins = sym_r[SYM_W+7:8];
endmodule : ppcs_link_partner

`default_nettype wire

// [bench/tb_ppcs_top.sv]
// Self-checking bench of the PHY port control and status bank.
// Assumes the package, the design and the link partner model are compiled first.

`timescale 1ns/1ps
`default_nettype none

module tb_ppcs_top;
  localparam int SW = 5;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, slow, dis_s, x_s;
  logic [ppcs_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] st1, st2, p1_st, p2_st;
  logic [SW-1:0] rx1, rx2, mac1, mac2, tx1, tx2;
  ppcs_pkg::ppcs_phy_ctl_t p1_ctl, p2_ctl;
  logic [32:0] rd_q [$];
  int err_total = 0;
  int checks_done = 0;

  ppcs_top #(.SYM_W(SW)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p1_phy_status(p1_st), .p2_phy_status(p2_st),
    .port2_crossover_dis_strap(dis_s), .port2_crossover_strap(x_s),
    .p1_ctl(p1_ctl), .p2_ctl(p2_ctl),
    .first_port_receive_pins(rx1), .second_port_receive_pins(rx2),
    .p1_mac_tx_sym(mac1), .p2_mac_tx_sym(mac2),
    .first_port_transmit_pins(tx1), .second_port_transmit_pins(tx2), .irq(irq)
  );

  ppcs_link_partner #(.SYM_W(SW)) u_partner (
    .pclk(pclk), .slow(slow), .st1_want(st1), .st2_want(st2),
    .p1_phy_status(p1_st), .p2_phy_status(p2_st),
    .first_port_receive_pins(rx1), .second_port_receive_pins(rx2)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  // One APB transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic apb_rd(input logic [11:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask : apb_rd

  // Read results are matched against the oldest note, {pslverr, prdata}
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) chk("unexpected read", 33'h0, 33'h1);
      else chk("apb read", rd_q.pop_front(), {pslverr, prdata});
    end
  end

  function automatic logic [32:0] ctl_exp(input logic [7:0] w, input logic st7);
    return {28'h0, w[4], w[3], ~w[2], w[2] ? w[1] : ~st7, w[0]};
  endfunction : ctl_exp

  initial begin
    repeat (10000) @(posedge pclk);
    err_total++;
    end_of_test();
  end

  initial begin
    logic [7:0] w1, w2, c1, c2;
    logic [SW-1:0] r1, r2, m1, m2;
    void'($urandom(32'hC8B93F79));
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    slow = 1'b0;
    dis_s = 1'($urandom);
    x_s = 1'($urandom);
    st1 = 8'($urandom);
    st2 = 8'($urandom);
    mac1 = '0;
    mac2 = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(8);
    // Reset values, port two taking its crossover bits from the straps
    apb_rd(12'h074, 33'h0);
    apb_rd(12'h0B4, {30'h0, dis_s, x_s, 1'b0});
    apb_rd(12'h104, 33'h0);
    chk("p2 ctl reset", ctl_exp({5'h0, dis_s, x_s, 1'b0}, st2[7]), {28'h0, p2_ctl});
    // Control write and read back, back to back
    for (int i = 0; i < 4; i++) begin
      w1 = 8'($urandom);
      w2 = 8'($urandom);
      apb(1'b1, 12'h074, {24'h0, w1});
      apb(1'b1, 12'h0B4, {24'h0, w2});
      apb_rd(12'h074, {25'h0, w1 & 8'h1F});
      apb_rd(12'h0B4, {25'h0, w2 & 8'h0F});
      tick(1);
      chk("p1 ctl", ctl_exp(w1 & 8'h1F, st1[7]), {28'h0, p1_ctl});
      chk("p2 ctl", ctl_exp(w2 & 8'h0F, st2[7]), {28'h0, p2_ctl});
    end
    // Live status, prompt and slow partner; writes there change nothing
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      st1 = 8'($urandom);
      st2 = 8'($urandom);
      tick(12);
      apb_rd(12'h078, {25'h0, st1});
      apb(1'b1, 12'h078, {24'h0, ~st1});
      apb_rd(12'h078, {25'h0, st1});
      apb_rd(12'h0B8, {25'h0, st2});
    end
    apb_rd(12'h0F8, 33'h0);
    apb_rd(12'h0FC, {1'b1, 32'h0});
    apb_rd(12'h07A, {1'b1, 32'h0});
    // Every mix of loopback and power-down on both ports
    for (int k = 0; k < 16; k++) begin
      c1 = {4'h0, k[2], 2'h0, k[0]};
      c2 = {4'h0, k[3], 2'h0, k[1]};
      apb(1'b1, 12'h074, {24'h0, c1});
      apb(1'b1, 12'h0B4, {24'h0, c2});
      tick(2);
      for (int j = 0; j < 4; j++) begin
        @(posedge pclk);
        mac1 <= SW'($urandom);
        mac2 <= SW'($urandom);
        #1;
        if (j > 0) begin
          chk("port1 tx", 33'(c1[3] ? '0 : (c2[0] ? r1 : m1)), 33'(tx1));
          chk("port2 tx", 33'(c2[3] ? '0 : (c1[0] ? r2 : m2)), 33'(tx2));
        end
        r1 = rx1;
        r2 = rx2;
        m1 = mac1;
        m2 = mac2;
      end
    end
    // Clock enable low freezes the transmit register; normal path resumes after
    apb(1'b1, 12'h074, 32'h0000_0000);
    apb(1'b1, 12'h0B4, 32'h0000_0000);
    m1 = SW'($urandom);
    m2 = ~m1;
    @(posedge pclk);
    mac1 <= m1;
    tick(2);
    @(posedge pclk);
    ce <= 1'b0;
    mac1 <= m2;
    tick(3);
    chk("frozen tx", 33'(m1), 33'(tx1));
    @(posedge pclk);
    ce <= 1'b1;
    tick(2);
    chk("resumed tx", 33'(m2), 33'(tx1));
    // Sticky events, masking and clearing
    st1[5] = 1'b0;
    st2[6] = 1'b0;
    tick(12);
    apb(1'b1, 12'h108, 32'h0000_000F);
    apb_rd(12'h100, 33'h0);
    apb(1'b1, 12'h104, 32'h0000_0009);
    st1[5] = 1'b1;
    st2[6] = 1'b1;
    tick(12);
    chk("irq raised", 33'h1, {32'h0, irq});
    apb_rd(12'h100, 33'h9);
    apb(1'b1, 12'h104, 32'h0000_0000);
    tick(1);
    chk("irq masked", 33'h0, {32'h0, irq});
    apb(1'b1, 12'h104, 32'h0000_0001);
    apb_rd(12'h104, 33'h1);
    apb(1'b1, 12'h108, 32'h0000_0001);
    tick(1);
    chk("irq cleared", 33'h0, {32'h0, irq});
    apb_rd(12'h100, 33'h8);
    apb_rd(12'h108, 33'h0);
    tick(4);
    chk("pending reads", 33'h0, 33'(rd_q.size()));
    end_of_test();
  end
endmodule : tb_ppcs_top

`default_nettype wire
